/* hdl/phy_ctrl_defines.vh */
`ifndef PHY_CTRL_DEFINES_VH
`define PHY_CTRL_DEFINES_VH

// Register numbers on the management link.
`define PHY_REG_BASIC_CONTROL 5'h00
`define PHY_REG_BASIC_STATUS 5'h01
`define PHY_REG_IDENTIFIER_HIGH 5'h02
`define PHY_REG_IDENTIFIER_LOW 5'h03
`define PHY_REG_NEGOTIATION_ADVERTISE 5'h04
`define PHY_REG_PARTNER_ABILITY 5'h05
`define PHY_REG_NEGOTIATION_EXPANSION 5'h06
`define PHY_REG_NEGOTIATION_NEXT_PAGE 5'h07
`define PHY_REG_PARTNER_NEXT_PAGE 5'h08
`define PHY_REG_RESERVED_NINE 5'h09
`define PHY_REG_DIGITAL_CONTROL_RESERVED 5'h10
`define PHY_REG_ANALOG_FRONTEND_CONTROL 5'h11
`define PHY_REG_RESERVED_TWELVE_BLOCK 5'h12
`define PHY_REG_RECEIVE_ERROR_COUNTER 5'h15
`define PHY_REG_STRAP_OVERRIDE 5'h16
`define PHY_REG_STRAP_STATUS 5'h17
`define PHY_REG_EXPANDED_CONTROL 5'h18
`define PHY_REG_RESERVED_NINETEEN_BLOCK 5'h19
`define PHY_REG_INTERRUPT_CONTROL_STATUS 5'h1B
`define PHY_REG_RESERVED_1C 5'h1C
`define PHY_REG_CABLE_DIAG_CONTROL_STATUS 5'h1D
`define PHY_REG_TRANSCEIVER_CONTROL_ONE 5'h1E
`define PHY_REG_TRANSCEIVER_CONTROL_TWO 5'h1F

// Bit positions in the basic control register.
`define BC_SOFT_RESET 15
`define BC_LOOPBACK 14
`define BC_SPEED_100 13
`define BC_AN_ENABLE 12
`define BC_POWER_DOWN 11
`define BC_ISOLATE 10
`define BC_AN_RESTART 9
`define BC_FULL_DUPLEX 8
`define BC_COLLISION_TEST 7
`define BC_RESERVED_ZERO 7'h00

// Fixed reset values of the bits that have no strap.
`define BC_LOOPBACK_RST 1'b0
`define BC_POWER_DOWN_RST 1'b0
`define BC_COLLISION_TEST_RST 1'b0

// Management frame layout.
`define MDIO_PREAMBLE_BITS 6'h20
`define MDIO_HDR_LAST 6'h0C
`define MDIO_DATA_LAST 6'h0F
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_READ_IDLE 16'h0000

// Self-clearing hold times in clock cycles.
`define SOFT_RESET_HOLD_CYCLES 16
`define AN_RESTART_HOLD_CYCLES 1

`endif

/* hdl/self_clear_bit.v */
// A command bit that reads one from its set until it clears itself.
module self_clear_bit #(
  parameter HOLD = 1
) (
  // Clock and reset.
  input wire i_clk,
  input wire i_reset,
  // Command.
  input wire i_set,
  // State.
  output wire o_active,
  output reg o_done
);

  reg [15:0] count_r;

  // The count runs down while active; a set during a run is ignored.
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      count_r <= 16'h0000;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (count_r != 16'h0000) begin
        count_r <= count_r - 16'h0001;
        if (count_r == 16'h0001) begin
          o_done <= 1'b1;
        end
      end else if (i_set) begin
        count_r <= HOLD[15:0];
      end
    end
  end

  assign o_active = (count_r != 16'h0000);

endmodule

/* hdl/phy_basic_control_regs.v */
// Operation
// - Reset bit starts soft reset, then self-clears.
// - Restart bit restarts negotiation, then self-clears.
// - Speed bit picks 100/10, unless negotiation enabled.
// - Negotiation result overrides speed and duplex bits.
// - Reset from power-down: first clears, second resets.
// - Isolate bit cuts transceiver off MAC interface.
// - Duplex bit full when one; default inverted strap.
// - Speed bit reset value from speed strap.
// - Negotiation enable reset value from its strap.
// - Isolate bit reset value from isolate strap.
`include "phy_ctrl_defines.vh"

module phy_basic_control_regs #(
  parameter SW_RESET_CYCLES = `SOFT_RESET_HOLD_CYCLES,
  parameter AN_RESTART_CYCLES = `AN_RESTART_HOLD_CYCLES
) (
  // Clock and reset.
  input wire i_ref_clk,
  input wire i_reset,
  // Serial management link.
  input wire i_mdc,
  input wire i_mdio,
  output wire o_mdio,
  output wire o_mdio_oe,
  input wire [4:0] i_phy_addr,
  // Strap inputs, caught after reset.
  input wire i_strap_speed,
  input wire i_negotiation_enable_strap,
  input wire i_strap_isolate,
  input wire i_strap_duplex,
  // Negotiation result from the link engine.
  input wire i_an_speed_100,
  input wire i_an_full_duplex,
  // Control outputs to the transceiver.
  output reg o_soft_reset,
  output reg o_an_restart,
  output reg o_loopback,
  output reg o_speed_100,
  output reg o_full_duplex,
  output reg o_an_enable,
  output reg o_power_down,
  output reg o_isolate,
  output reg o_collision_test
);

  // Frame receiver states.
  localparam ST_PRE = 2'h0;
  localparam ST_HDR = 2'h1;
  localparam ST_TA = 2'h2;
  localparam ST_DATA = 2'h3;

  // Link sampling and frame state.
  reg mdc_prev_r;
  reg [1:0] state_r;
  reg [5:0] bit_cnt_r;
  reg [11:0] hdr_r;
  reg is_read_r;
  reg [4:0] reg_addr_r;
  reg [15:0] shift_r;
  reg mdio_out_r;
  reg mdio_oe_r;
  reg wr_en_r;
  reg [15:0] wr_data_r;

  // Control register fields.
  reg strap_load_r;
  reg loopback_r;
  reg speed_r;
  reg an_en_r;
  reg pdown_r;
  reg iso_r;
  reg duplex_r;
  reg coltest_r;

  // Decoded frame and control strobes.
  wire mdc_rise;
  wire [12:0] hdr_word;
  wire hdr_ok;
  wire ctrl_write;
  wire reset_req;
  wire srst_start;
  wire srst_active;
  wire srst_done;
  wire restart_start;
  wire restart_active;
  wire [15:0] ctrl_word;
  reg [15:0] rd_data;

  // The link clock is an ordinary input here, so an edge is a sampled rise.
  // Its idle level is low, so the reset value of the previous sample
  // cannot fake a rise just after reset.
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      mdc_prev_r <= 1'b0;
    end else begin
      mdc_prev_r <= i_mdc;
    end
  end

  assign mdc_rise = i_mdc & ~mdc_prev_r;

  // Second start bit, opcode, device address and register number.
  // The second start bit must be one; a frame without it is dropped.
  assign hdr_word = {hdr_r, i_mdio};
  assign hdr_ok = hdr_word[12] && (hdr_word[9:5] == i_phy_addr) &&
    ((hdr_word[11:10] == `MDIO_OP_READ) || (hdr_word[11:10] == `MDIO_OP_WRITE));

  // Frame receiver. A frame for another address is dropped and the
  // receiver waits for a fresh preamble, so it never drives a shared line.
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ST_PRE;
      bit_cnt_r <= 6'h00;
      hdr_r <= 12'h000;
      is_read_r <= 1'b0;
      reg_addr_r <= 5'h00;
      shift_r <= 16'h0000;
      mdio_out_r <= 1'b0;
      mdio_oe_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_data_r <= 16'h0000;
    end else begin
      wr_en_r <= 1'b0;
      if (mdc_rise) begin
        case (state_r)
          // Ones are counted up to a full preamble and held there; a zero
          // after a full count is the first start bit, and a zero after a
          // short run throws the count away so a noisy line cannot sneak
          // a frame in.
          ST_PRE: begin
            if (i_mdio) begin
              if (bit_cnt_r != `MDIO_PREAMBLE_BITS) begin
                bit_cnt_r <= bit_cnt_r + 6'h01;
              end
            end else if (bit_cnt_r == `MDIO_PREAMBLE_BITS) begin
              state_r <= ST_HDR;
              bit_cnt_r <= 6'h00;
            end else begin
              bit_cnt_r <= 6'h00;
            end
          end
          // The header is judged only on its last bit, so a frame for
          // another address still runs its full length through here and
          // the receiver never lands in the data stage by accident.
          ST_HDR: begin
            hdr_r <= hdr_word[11:0];
            if (bit_cnt_r == `MDIO_HDR_LAST) begin
              bit_cnt_r <= 6'h00;
              if (hdr_ok) begin
                state_r <= ST_TA;
                is_read_r <= (hdr_word[11:10] == `MDIO_OP_READ);
                reg_addr_r <= hdr_word[4:0];
              end else begin
                state_r <= ST_PRE;
              end
            end else begin
              bit_cnt_r <= bit_cnt_r + 6'h01;
            end
          end
          // On a read the line is taken at the first turnaround rise. The
          // controller has let go by then, and it samples the driven zero
          // during the second turnaround bit, as the frame expects.
          ST_TA: begin
            if (bit_cnt_r == 6'h00) begin
              bit_cnt_r <= 6'h01;
              if (is_read_r) begin
                mdio_oe_r <= 1'b1;
                mdio_out_r <= 1'b0;
              end
            end else begin
              state_r <= ST_DATA;
              bit_cnt_r <= 6'h00;
              if (is_read_r) begin
                mdio_out_r <= rd_data[15];
                shift_r <= {rd_data[14:0], 1'b0};
              end
            end
          end
          // Reads shift out most significant bit first and let go of the
          // line at the rise that closes bit zero. Writes gather sixteen
          // bits and raise a one-clock strobe with the finished word.
          ST_DATA: begin
            if (is_read_r) begin
              if (bit_cnt_r == `MDIO_DATA_LAST) begin
                mdio_oe_r <= 1'b0;
                mdio_out_r <= 1'b0;
                state_r <= ST_PRE;
                bit_cnt_r <= 6'h00;
              end else begin
                mdio_out_r <= shift_r[15];
                shift_r <= {shift_r[14:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 6'h01;
              end
            end else begin
              shift_r <= {shift_r[14:0], i_mdio};
              if (bit_cnt_r == `MDIO_DATA_LAST) begin
                wr_en_r <= 1'b1;
                wr_data_r <= {shift_r[14:0], i_mdio};
                state_r <= ST_PRE;
                bit_cnt_r <= 6'h00;
              end else begin
                bit_cnt_r <= bit_cnt_r + 6'h01;
              end
            end
          end
          // Unused state codes fall back to hunting for a preamble.
          default: begin
            state_r <= ST_PRE;
            bit_cnt_r <= 6'h00;
          end
        endcase
      end
    end
  end

  assign o_mdio = mdio_out_r;
  assign o_mdio_oe = mdio_oe_r;

  // Write decode for the basic control register.
  assign ctrl_write = wr_en_r && (reg_addr_r == `PHY_REG_BASIC_CONTROL);
  assign reset_req = ctrl_write && wr_data_r[`BC_SOFT_RESET];
  // A reset write while powered down only wakes the device.
  assign srst_start = reset_req && !pdown_r && !srst_active;
  assign restart_start = ctrl_write && !reset_req && !srst_active &&
    wr_data_r[`BC_AN_RESTART];

  // Soft reset holds for a fixed time, then reloads every default.
  self_clear_bit #(
    .HOLD(SW_RESET_CYCLES)
  ) u_soft_reset (
    .i_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_set(srst_start),
    .o_active(srst_active),
    .o_done(srst_done)
  );

  // Negotiation restart reads one for its hold and then clears itself.
  // A restart written along with a reset bit is dropped, since the reset
  // that follows returns every field to its default.
  self_clear_bit #(
    .HOLD(AN_RESTART_CYCLES)
  ) u_an_restart (
    .i_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_set(restart_start),
    .o_active(restart_active),
    .o_done()
  );

  // Control fields. Straps are caught by the clock after reset release,
  // never by the asynchronous reset itself, and again after a soft reset.
  // Writes that land while a soft reset runs are dropped, since the
  // reload at its end would overwrite them anyway.
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      strap_load_r <= 1'b1;
      loopback_r <= `BC_LOOPBACK_RST;
      speed_r <= 1'b0;
      an_en_r <= 1'b0;
      pdown_r <= `BC_POWER_DOWN_RST;
      iso_r <= 1'b0;
      duplex_r <= 1'b0;
      coltest_r <= `BC_COLLISION_TEST_RST;
    end else if (strap_load_r || srst_done) begin
      strap_load_r <= 1'b0;
      loopback_r <= `BC_LOOPBACK_RST;
      speed_r <= i_strap_speed;
      an_en_r <= i_negotiation_enable_strap;
      pdown_r <= `BC_POWER_DOWN_RST;
      iso_r <= i_strap_isolate;
      duplex_r <= ~i_strap_duplex;
      coltest_r <= `BC_COLLISION_TEST_RST;
    end else if (ctrl_write && !srst_active) begin
      if (reset_req) begin
        if (pdown_r) begin
          pdown_r <= 1'b0;
        end
      end else begin
        loopback_r <= wr_data_r[`BC_LOOPBACK];
        speed_r <= wr_data_r[`BC_SPEED_100];
        an_en_r <= wr_data_r[`BC_AN_ENABLE];
        pdown_r <= wr_data_r[`BC_POWER_DOWN];
        iso_r <= wr_data_r[`BC_ISOLATE];
        duplex_r <= wr_data_r[`BC_FULL_DUPLEX];
        coltest_r <= wr_data_r[`BC_COLLISION_TEST];
      end
    end
  end

  // Read view of the basic control register; the low bits stay zero.
  // Bits fifteen and nine show the running self-clearing commands.
  assign ctrl_word = {srst_active, loopback_r, speed_r, an_en_r, pdown_r,
    iso_r, restart_active, duplex_r, coltest_r, `BC_RESERVED_ZERO};

  // Read mux. The other registers of the map exist on the link, but
  // their contents are kept by other blocks, so they read zero here.
  // The address is held from the header, so the word is settled well
  // before the second turnaround rise loads it into the shifter.
  always @* begin
    case (reg_addr_r)
      `PHY_REG_BASIC_CONTROL: begin
        rd_data = ctrl_word;
      end
      default: begin
        rd_data = `MDIO_READ_IDLE;
      end
    endcase
  end

  // Outputs to the transceiver, registered so they never glitch.
  // They trail the register fields by one clock, which is the price
  // paid for glitch-free levels at the transceiver.
  // With negotiation on, the negotiated speed and duplex win over the
  // manual bits, which keep their stored value for a later manual mode.
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_soft_reset <= 1'b0;
      o_an_restart <= 1'b0;
      o_loopback <= 1'b0;
      o_speed_100 <= 1'b0;
      o_full_duplex <= 1'b0;
      o_an_enable <= 1'b0;
      o_power_down <= 1'b0;
      o_isolate <= 1'b0;
      o_collision_test <= 1'b0;
    end else begin
      o_soft_reset <= srst_active;
      o_an_restart <= restart_active && an_en_r;
      o_loopback <= loopback_r;
      o_speed_100 <= an_en_r ? i_an_speed_100 : speed_r;
      o_full_duplex <= an_en_r ? i_an_full_duplex : duplex_r;
      o_an_enable <= an_en_r;
      o_power_down <= pdown_r;
      o_isolate <= iso_r;
      o_collision_test <= coltest_r;
    end
  end

endmodule

/* tb/phy_ctrl_properties.sv */
module phy_ctrl_checker #(
  parameter SW_RESET_CYCLES = 16
) (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_strap_isolate,
  input wire i_negotiation_enable_strap,
  input wire i_an_speed_100,
  input wire i_an_full_duplex,
  input wire o_soft_reset,
  input wire o_an_restart,
  input wire o_an_enable,
  input wire o_speed_100,
  input wire o_full_duplex,
  input wire o_power_down,
  input wire o_isolate
);
  timeunit 1ns;
  timeprecision 1ns;
  int hi_cnt;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Counts how long soft reset has stood, so its length is checked exactly.
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= o_soft_reset ? hi_cnt + 1 : 0;
    end
  end
  // Restart is a single-cycle pulse; the isolate and negotiation enable straps show again after reload.
  sequence s_pulse;
    o_an_restart ##1 !o_an_restart;
  endsequence
  sequence s_reload;
    (o_isolate == i_strap_isolate) && (o_an_enable == i_negotiation_enable_strap);
  endsequence
  property p_restart_width;
    $rose(o_an_restart) |-> s_pulse;
  endproperty
  property p_restart_gated;
    o_an_restart |-> (o_an_enable || $past(o_an_enable)) or (##[1:2] o_an_enable);
  endproperty
  property p_sr_len;
    $fell(o_soft_reset) |-> hi_cnt == SW_RESET_CYCLES;
  endproperty
  property p_sr_bound;
    $rose(o_soft_reset) |-> ##[1:40] !o_soft_reset;
  endproperty
  property p_speed_an;
    o_an_enable && $past(o_an_enable) && !o_soft_reset |-> o_speed_100 == $past(i_an_speed_100);
  endproperty
  property p_duplex_an;
    o_an_enable && $past(o_an_enable) && !o_soft_reset |->
      o_full_duplex == $past(i_an_full_duplex);
  endproperty
  property p_pd_exit;
    $fell(o_power_down) |-> !o_soft_reset[*3];
  endproperty
  property p_reload;
    $fell(o_soft_reset) |-> ##[1:3] s_reload;
  endproperty
  a_restart_width: assert property (p_restart_width) else $error("restart not one cycle");
  a_restart_gated: assert property (p_restart_gated) else $error("restart without enable");
  a_sr_len: assert property (p_sr_len) else $error("soft reset length wrong");
  a_sr_bound: assert property (p_sr_bound) else $error("soft reset stuck");
  a_speed_an: assert property (p_speed_an) else $error("speed not negotiated");
  a_duplex_an: assert property (p_duplex_an) else $error("duplex not negotiated");
  a_pd_exit: assert property (p_pd_exit) else $error("reset on power-down exit");
  a_reload: assert property (p_reload) else $error("straps not reloaded");
endmodule

bind phy_basic_control_regs phy_ctrl_checker #(.SW_RESET_CYCLES(SW_RESET_CYCLES)) chk_u (
  .i_ref_clk, .i_reset, .i_strap_isolate, .i_negotiation_enable_strap, .i_an_speed_100,
  .i_an_full_duplex, .o_soft_reset, .o_an_restart, .o_an_enable, .o_speed_100,
  .o_full_duplex, .o_power_down, .o_isolate);

/* tb/mgmt_station.sv */
module mgmt_station (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_mdc,
  output logic o_mdio,
  output logic o_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  // The management clock stands still low between frames.
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_drive = 1'b0;
  end
  // Data changes while the clock is low and is sampled just before the rise.
  task automatic bit_cyc(input logic drv, input logic v, output logic s);
    o_mdc <= 1'b0;
    o_drive <= drv;
    o_mdio <= v;
    repeat (2) @(posedge i_clk);
    s = i_line;
    o_mdc <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask
  // One whole frame; on a read the line is released from turnaround on.
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    logic wr;
    hdr = {2'b01, op, pa, ra};
    wr = (op == 2'h1);
    repeat (32) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    bit_cyc(wr, 1'b1, s);
    bit_cyc(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(wr, wd[i], s);
      rd[i] = s;
    end
    o_mdc <= 1'b0;
    o_drive <= 1'b0;
    // Let an edge pass so a frame that follows never assigns these twice at once.
    @(posedge i_clk);
  endtask
endmodule

/* tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, mdc, st_out, st_drv, d_out, d_oe;
  logic s_spd, s_neg, s_iso, s_dup, an_spd, an_dup;
  logic o_sr, o_ar, o_lb, o_spd, o_fd, o_an, o_pd, o_iso, o_col;
  logic [4:0] fa;
  int n_fail, comparisons, n_ar, n_sr;
  wire line;
  // Pulled-up line: whoever enables drives it, else it floats high.
  assign line = d_oe ? d_out : (st_drv ? st_out : 1'b1);
  mgmt_station sta_u (.i_clk(clk), .i_line(line), .o_mdc(mdc), .o_mdio(st_out),
    .o_drive(st_drv));
  phy_basic_control_regs #(.SW_RESET_CYCLES(4)) dut_u (.i_ref_clk(clk), .i_reset(rst),
    .i_mdc(mdc), .i_mdio(line), .o_mdio(d_out), .o_mdio_oe(d_oe), .i_phy_addr(5'h03),
    .i_strap_speed(s_spd), .i_negotiation_enable_strap(s_neg), .i_strap_isolate(s_iso),
    .i_strap_duplex(s_dup), .i_an_speed_100(an_spd), .i_an_full_duplex(an_dup),
    .o_soft_reset(o_sr), .o_an_restart(o_ar), .o_loopback(o_lb), .o_speed_100(o_spd),
    .o_full_duplex(o_fd), .o_an_enable(o_an), .o_power_down(o_pd), .o_isolate(o_iso),
    .o_collision_test(o_col));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cycles of restart and soft reset seen, to check pulse lengths.
  always @(posedge clk) begin
    n_ar <= n_ar + int'(o_ar);
    n_sr <= n_sr + int'(o_sr);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [7:0] e);
    chk({8'h00, o_sr, o_lb, o_spd, o_an, o_pd, o_iso, o_fd, o_col}, {8'h00, e});
  endtask
  // Writes wait for the update to reach the outputs.
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    sta_u.frame(2'h1, fa, ra, d, x);
    repeat (4) @(posedge clk);
  endtask
  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] x;
    sta_u.frame(2'h2, fa, ra, 16'h0000, x);
    chk(x, e);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end
  initial begin
    n_fail = 0;
    comparisons = 0;
    n_ar = 0;
    n_sr = 0;
    rst = 1'b1;
    fa = 5'h03;
    {s_spd, s_neg, s_iso, s_dup, an_spd, an_dup} = 6'b101011;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(5'h00, 16'h2500);
    chk_out(8'h26);
    $display("test reset values done");
    wr(5'h00, 16'h40FF);
    rd_chk(5'h00, 16'h4080);
    chk_out(8'h41);
    wr(5'h00, 16'h2100);
    chk_out(8'h22);
    $display("test manual fields done");
    an_spd <= 1'b0;
    an_dup <= 1'b0;
    wr(5'h00, 16'h3300);
    chk_out(8'h10);
    chk(16'(n_ar), 16'h0001);
    rd_chk(5'h00, 16'h3100);
    an_spd <= 1'b1;
    an_dup <= 1'b1;
    repeat (3) @(posedge clk);
    chk_out(8'h32);
    $display("test negotiation done");
    wr(5'h00, 16'h0800);
    chk_out(8'h08);
    {s_spd, s_neg, s_iso, s_dup} <= 4'b0101;
    wr(5'h00, 16'h8000);
    chk_out(8'h00);
    chk(16'(n_sr), 16'h0000);
    rd_chk(5'h00, 16'h0000);
    wr(5'h00, 16'h8000);
    repeat (8) @(posedge clk);
    chk(16'(n_sr), 16'h0004);
    rd_chk(5'h00, 16'h1000);
    chk_out(8'h32);
    $display("test power-down exit done");
    fa = 5'h04;
    wr(5'h00, 16'h4000);
    fa = 5'h03;
    rd_chk(5'h00, 16'h1000);
    wr(5'h09, 16'hFFFF);
    rd_chk(5'h09, 16'h0000);
    $display("test refused access done");
    final_report();
  end
endmodule
